//--- ring_ctrl_pkg.sv
package ring_ctrl_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ID_CMD_OFFSET = 8'h00;
  localparam logic [7:0]  CONFIG_OFFSET = 8'h02;
  localparam logic [15:0] CONFIG_RESET  = 16'h0000;

  // command bits of identification_command_reg on write
  localparam int CMD_TOKEN_LAUNCH_BIT   = 0;
  localparam int CMD_WATCHDOG_CLEAR_BIT = 1;
  localparam int CMD_SOFTWARE_RESET_BIT = 2;

  // identification code field positions
  localparam int ID_VERSION_LSB  = 0;
  localparam int ID_REVISION_LSB = 4;
  localparam int ID_FOUNDRY_LSB  = 8;
  localparam int ID_TYPE_LSB     = 12;
  localparam int ID_FIELD_W      = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 8;
  localparam int STAMP_STEP_MS    = 250;
  localparam int STAMP_STEP_CYC   = (STAMP_STEP_MS * 1000000) / CLK_PERIOD_NS;
  localparam logic [15:0] STAMP_TOP   = 16'hffff;
  localparam logic [15:0] DECIMAL_MAX = 16'h9999;
  localparam logic [5:0]  SYNC_DIV_VCXO = 6'h20;
  localparam logic [5:0]  SYNC_DIV_XO   = 6'h1e;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [10:0] upper;
    logic        oscillator_mode_select;
    logic        timestamp_validate;
    logic        token_ring_disable;
    logic        priority_memory_access;
    logic        watchdog_disable;
  } config_t;

  typedef struct packed {
    logic        token_launch;
    logic        watchdog_clear;
    logic        software_reset;
  } cmd_t;

  typedef enum logic [1:0] {
    TOK_NONE = 2'b00,
    TOK_HELD = 2'b01,
    TOK_PASS = 2'b11
  } token_state_t;

endpackage

//--- tick_divider.sv
`timescale 1ns/1ps
module tick_divider
  import ring_ctrl_pkg::*;
#(
  parameter int W = 6
)(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clear,
  input  wire logic [W-1:0] divisor,
  output logic              tick
);

  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
    end
    else if (clear || (cnt_q >= divisor - W'(1)))
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  assign tick = !clear && (cnt_q >= divisor - W'(1));

endmodule

//--- token_ring_global_control.sv
`timescale 1ns/1ps
// Function
// - reading identification register returns fixed code
// - code fields: version, revision, foundry, type
// - token launch bit emits token output pulse
// - watchdog clear bit restarts watchdog interval
// - software reset bit resets config, token, stamp, watchdog and dividers
// - command bits self-clear after each write
// - watchdog disabled keeps watchdog output low
// - watchdog fires if not cleared in time
// - priority access captures and keeps token
// - otherwise one access then pass token
// - ring disable destroys token, blocks access
// - ring enabled lets launched token appear
// - validated stamp: binary down-count, 250 ms steps
// - otherwise decimal counter for watchdog/timer
// - sync divider divides by 32 or 30
// - token output on rising, token input on falling edge
module token_ring_global_control
  import ring_ctrl_pkg::*;
#(
  parameter int          STEP_CYCLES = STAMP_STEP_CYC,
  parameter logic [3:0]  ID_VERSION  = 4'h1,  // arbitrary value
  parameter logic [3:0]  ID_REVISION = 4'h2,  // arbitrary value
  parameter logic [3:0]  ID_FOUNDRY  = 4'h3,  // arbitrary value
  parameter logic [3:0]  ID_TYPE     = 4'h4   // arbitrary value
)(
  input  wire logic        CLK_SYS,
  input  wire logic        RESET_N,
  input  wire logic        PROC_STROBE_N,
  input  wire logic        PROC_READ,
  input  wire logic [7:0]  PROC_ADDR,
  input  wire logic [15:0] PROC_WDATA,
  output logic [15:0]      PROC_RDATA,
  output logic             PROC_RDATA_OE,
  output logic             PROC_ACK_N,
  input  wire logic        TOKEN_IN,
  output logic             TOKEN_OUT,
  input  wire logic        MEM_REQ,
  input  wire logic        MEM_DONE,
  output logic             MEM_GRANT,
  input  wire logic [15:0] TIMER_PRESET,
  output logic             WATCHDOG_OUT,
  output logic [15:0]      TIMESTAMP,
  output logic             SYNC_TICK,
  output logic             SOFT_RESET_OUT
);

  // ----------------------------------------------------------------
  // identification code
  // ----------------------------------------------------------------
  // field packing
  localparam logic [15:0] ID_CODE = {ID_TYPE, ID_FOUNDRY, ID_REVISION, ID_VERSION};

  // ----------------------------------------------------------------
  // processor strobe synchroniser
  // ----------------------------------------------------------------
  logic strobe_meta_q;
  logic strobe_sync_q;
  logic strobe_prev_q;
  logic access_start;
  logic soft_q;

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      strobe_meta_q <= 1'b0;
      strobe_sync_q <= 1'b0;
      strobe_prev_q <= 1'b0;
    end
    else
    begin
      strobe_meta_q <= ~PROC_STROBE_N;
      strobe_sync_q <= strobe_meta_q;
      strobe_prev_q <= strobe_sync_q;
    end
  end

  // address and data are held by the processor while the strobe is low
  assign access_start = strobe_sync_q && !strobe_prev_q;

  logic wr_id_cmd;
  logic wr_config;
  assign wr_id_cmd = access_start && !PROC_READ && (PROC_ADDR == ID_CMD_OFFSET);
  assign wr_config = access_start && !PROC_READ && (PROC_ADDR == CONFIG_OFFSET);

  // ----------------------------------------------------------------
  // one-shot commands
  // ----------------------------------------------------------------
  cmd_t cmd_q;

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      cmd_q <= '0;
    end
    else if (wr_id_cmd)
    begin
      cmd_q.token_launch   <= PROC_WDATA[CMD_TOKEN_LAUNCH_BIT];
      cmd_q.watchdog_clear <= PROC_WDATA[CMD_WATCHDOG_CLEAR_BIT];
      cmd_q.software_reset <= PROC_WDATA[CMD_SOFTWARE_RESET_BIT];
    end
    else
    begin
      cmd_q <= '0;
    end
  end

  // software reset acts like the pin on config, token, stamp, watchdog and dividers
  // synchronous clear avoids a glitchy derived asynchronous reset
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      soft_q <= 1'b0;
    end
    else
    begin
      soft_q <= cmd_q.software_reset;
    end
  end

  assign SOFT_RESET_OUT = soft_q;

  // ----------------------------------------------------------------
  // general configuration register
  // ----------------------------------------------------------------
  config_t config_q;

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      config_q <= config_t'(CONFIG_RESET);
    end
    else if (soft_q)
    begin
      config_q <= config_t'(CONFIG_RESET);
    end
    else if (wr_config)
    begin
      config_q <= config_t'(PROC_WDATA);
    end
  end

  // ----------------------------------------------------------------
  // read path and acknowledge
  // ----------------------------------------------------------------
  logic        ack_q;
  logic        rd_oe_q;
  logic [15:0] rdata_q;

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ack_q   <= 1'b0;
      rd_oe_q <= 1'b0;
      rdata_q <= 16'h0000;
    end
    else if (access_start)
    begin
      ack_q   <= 1'b1;
      rd_oe_q <= PROC_READ;
      // fixed code, untouched by any reset
      if (PROC_ADDR == ID_CMD_OFFSET)
      begin
        rdata_q <= ID_CODE;
      end
      else if (PROC_ADDR == CONFIG_OFFSET)
      begin
        rdata_q <= config_q;
      end
      else
      begin
        rdata_q <= 16'h0000;
      end
    end
    else if (!strobe_sync_q)
    begin
      ack_q   <= 1'b0;
      rd_oe_q <= 1'b0;
    end
  end

  assign PROC_RDATA    = rdata_q;
  assign PROC_RDATA_OE = rd_oe_q;
  assign PROC_ACK_N    = ~ack_q;

  // ----------------------------------------------------------------
  // token input capture
  // ----------------------------------------------------------------
  logic tok_fall_q;
  logic tok_meta_q;
  logic tok_sync_q;
  logic tok_prev_q;
  logic tok_arrive;

  // token input taken on falling edge
  always_ff @(negedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      tok_fall_q <= 1'b0;
    end
    else
    begin
      tok_fall_q <= TOKEN_IN;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      tok_meta_q <= 1'b0;
      tok_sync_q <= 1'b0;
      tok_prev_q <= 1'b0;
    end
    else
    begin
      tok_meta_q <= tok_fall_q;
      tok_sync_q <= tok_meta_q;
      tok_prev_q <= tok_sync_q;
    end
  end

  assign tok_arrive = tok_sync_q && !tok_prev_q;

  // ----------------------------------------------------------------
  // token state machine
  // ----------------------------------------------------------------
  token_state_t tok_q;
  logic         pass_now;
  logic         tok_out_q;

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      tok_q <= TOK_NONE;
    end
    else if (soft_q)
    begin
      tok_q <= TOK_NONE;
    end
    else
    begin
      unique case (tok_q)
        TOK_NONE:
        begin
          if (tok_arrive && !config_q.token_ring_disable)
          begin
            if (config_q.priority_memory_access || MEM_REQ)
            begin
              tok_q <= TOK_HELD;
            end
            else
            begin
              tok_q <= TOK_PASS;
            end
          end
        end
        TOK_HELD:
        begin
          if (config_q.token_ring_disable)
          begin
            tok_q <= TOK_NONE;
          end
          else if (!config_q.priority_memory_access && (MEM_DONE || !MEM_REQ))
          begin
            tok_q <= TOK_PASS;
          end
        end
        TOK_PASS:
        begin
          tok_q <= TOK_NONE;
        end
        default:
        begin
          tok_q <= TOK_NONE;
        end
      endcase
    end
  end

  assign pass_now = (tok_q == TOK_PASS) && !config_q.token_ring_disable;

  // only while the ring is enabled
  // token output changes on rising edge
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      tok_out_q <= 1'b0;
    end
    else if (soft_q)
    begin
      tok_out_q <= 1'b0;
    end
    else
    begin
      tok_out_q <= !config_q.token_ring_disable && (cmd_q.token_launch || pass_now);
    end
  end

  assign TOKEN_OUT = tok_out_q;
  assign MEM_GRANT = (tok_q == TOK_HELD) && !config_q.token_ring_disable;

  // ----------------------------------------------------------------
  // time-stamp counter and watchdog
  // ----------------------------------------------------------------
  logic        step_tick;
  logic        stamp_mode_prev_q;
  logic [15:0] stamp_q;
  logic        watchdog_q;

  tick_divider #(
    .W       (32)
  ) u_step_div (
    .clk     (CLK_SYS),
    .rst_n   (RESET_N),
    .clear   (soft_q),
    .divisor (32'(STEP_CYCLES)),
    .tick    (step_tick)
  );

  function automatic logic [15:0] bcd_inc(input logic [15:0] v);
    logic [15:0] r;
    logic        carry;
    r     = v;
    carry = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      if (carry)
      begin
        if (r[i*4 +: 4] == 4'h9)
        begin
          r[i*4 +: 4] = 4'h0;
        end
        else
        begin
          r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
          carry       = 1'b0;
        end
      end
    end
    return r;
  endfunction

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      stamp_mode_prev_q <= 1'b0;
      stamp_q           <= 16'h0000;
    end
    else if (soft_q)
    begin
      stamp_mode_prev_q <= 1'b0;
      stamp_q           <= 16'h0000;
    end
    else
    begin
      stamp_mode_prev_q <= config_q.timestamp_validate;
      if (config_q.timestamp_validate && !stamp_mode_prev_q)
      begin
        stamp_q <= STAMP_TOP;
      end
      else if (!config_q.timestamp_validate && stamp_mode_prev_q)
      begin
        stamp_q <= 16'h0000;
      end
      else if (cmd_q.watchdog_clear && !config_q.timestamp_validate)
      begin
        stamp_q <= 16'h0000;
      end
      else if (step_tick)
      begin
        if (config_q.timestamp_validate)
        begin
          stamp_q <= stamp_q - 16'h0001;
        end
        else if (stamp_q != DECIMAL_MAX)
        begin
          stamp_q <= bcd_inc(stamp_q);
        end
      end
    end
  end

  assign TIMESTAMP = stamp_q;

  // expiry wins over a clear in the same cycle
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      watchdog_q <= 1'b0;
    end
    else if (soft_q)
    begin
      watchdog_q <= 1'b0;
    end
    else if (config_q.watchdog_disable || config_q.timestamp_validate)
    begin
      watchdog_q <= 1'b0;
    end
    else if (stamp_q == TIMER_PRESET)
    begin
      watchdog_q <= 1'b1;
    end
    else if (cmd_q.watchdog_clear)
    begin
      watchdog_q <= 1'b0;
    end
  end

  assign WATCHDOG_OUT = watchdog_q;

  // ----------------------------------------------------------------
  // synchronization counter divider
  // ----------------------------------------------------------------
  logic [5:0] sync_div;
  logic       sync_tick_c;
  logic       sync_tick_q;

  assign sync_div = config_q.oscillator_mode_select ? SYNC_DIV_VCXO : SYNC_DIV_XO;

  tick_divider #(
    .W       (6)
  ) u_sync_div (
    .clk     (CLK_SYS),
    .rst_n   (RESET_N),
    .clear   (soft_q),
    .divisor (sync_div),
    .tick    (sync_tick_c)
  );

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      sync_tick_q <= 1'b0;
    end
    else
    begin
      sync_tick_q <= sync_tick_c;
    end
  end

  assign SYNC_TICK = sync_tick_q;

endmodule

//--- ring_neighbour.sv
`timescale 1ns/1ps
module ring_neighbour #(
  parameter int DLY = 5
)(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic token_out,
  input  wire logic pass_en,
  input  wire logic inject,
  output logic      token_in
);
  // ----------------------------------------
  // neighbour on the ring
  // ----------------------------------------
  logic [7:0] dly_q;
  logic [1:0] hold_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dly_q <= 8'h00;
    else if (token_out && pass_en)
      dly_q <= 8'(DLY);
    else if (dly_q != 8'h00)
      dly_q <= dly_q - 8'h01;
  end

  // rising edge only
  // held two cycles so the falling-edge sample sees a stable level
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hold_q <= 2'b00;
    else if (inject || dly_q == 8'h01)
      hold_q <= 2'b11;
    else
      hold_q <= hold_q >> 1;
  end

  assign token_in = hold_q[0];
endmodule

//--- ring_ctrl_properties.sv
`timescale 1ns/1ps
module ring_ctrl_props
  import ring_ctrl_pkg::*;
#(
  parameter logic [3:0] ID_VERSION  = 4'h1,
  parameter logic [3:0] ID_REVISION = 4'h2,
  parameter logic [3:0] ID_FOUNDRY  = 4'h3,
  parameter logic [3:0] ID_TYPE     = 4'h4
)(
  input wire logic        CLK_SYS,
  input wire logic        RESET_N,
  input wire logic        PROC_STROBE_N,
  input wire logic        PROC_READ,
  input wire logic [7:0]  PROC_ADDR,
  input wire logic [15:0] PROC_RDATA,
  input wire logic        PROC_RDATA_OE,
  input wire logic        PROC_ACK_N,
  input wire logic        TOKEN_OUT,
  input wire logic        MEM_DONE,
  input wire logic        MEM_GRANT,
  input wire logic [15:0] TIMER_PRESET,
  input wire logic        WATCHDOG_OUT,
  input wire logic [15:0] TIMESTAMP,
  input wire logic        SYNC_TICK,
  input wire logic        SOFT_RESET_OUT
);
  // ----------------------------------------
  // divider period helper
  // ----------------------------------------
  logic [5:0] gap_q;
  logic       seen_q;

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      gap_q <= 6'h00;
    else if (SYNC_TICK)
      gap_q <= 6'h00;
    else
      gap_q <= gap_q + 6'h01;
  end

  // any access may change the divisor mid-period
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      seen_q <= 1'b0;
    else if (!PROC_STROBE_N || !PROC_ACK_N || SOFT_RESET_OUT)
      seen_q <= 1'b0;
    else if (SYNC_TICK)
      seen_q <= 1'b1;
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  sequence s_done_drop;
    MEM_GRANT && MEM_DONE ##1 !MEM_GRANT;
  endsequence
  sequence s_stamp_leave;
    TIMESTAMP == 16'hffff ##1 TIMESTAMP != 16'hffff;
  endsequence

  token_pulse_a: assert property (TOKEN_OUT |=> !TOKEN_OUT)
    else $error("token pulse too long");
  reset_pulse_a: assert property (SOFT_RESET_OUT |=> !SOFT_RESET_OUT)
    else $error("reset command stuck");
  soft_clear_a: assert property (SOFT_RESET_OUT |-> ##[1:2]
    (TIMESTAMP == 16'h0000 && !WATCHDOG_OUT && !MEM_GRANT))
    else $error("soft reset left state");
  id_read_a: assert property ((PROC_READ && !PROC_STROBE_N && !PROC_ACK_N
    && PROC_RDATA_OE && PROC_ADDR == ID_CMD_OFFSET)
    |-> PROC_RDATA == {ID_TYPE, ID_FOUNDRY, ID_REVISION, ID_VERSION})
    else $error("bad id code");
  sync_period_a: assert property (SYNC_TICK && seen_q
    |-> gap_q == 6'h1d || gap_q == 6'h1f)
    else $error("bad divider period");
  pass_after_done_a: assert property (s_done_drop |-> ##[0:2] TOKEN_OUT)
    else $error("token not passed on");
  watchdog_match_a: assert property ($rose(WATCHDOG_OUT)
    |-> $past(TIMESTAMP) == $past(TIMER_PRESET))
    else $error("watchdog fired off match");
  stamp_down_a: assert property (s_stamp_leave
    |-> TIMESTAMP == 16'hfffe || TIMESTAMP == 16'h0000)
    else $error("stamp not counting down");
endmodule

bind token_ring_global_control ring_ctrl_props #(
  .ID_VERSION(ID_VERSION), .ID_REVISION(ID_REVISION),
  .ID_FOUNDRY(ID_FOUNDRY), .ID_TYPE(ID_TYPE)
) i_props (
  .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .PROC_STROBE_N(PROC_STROBE_N),
  .PROC_READ(PROC_READ), .PROC_ADDR(PROC_ADDR), .PROC_RDATA(PROC_RDATA),
  .PROC_RDATA_OE(PROC_RDATA_OE), .PROC_ACK_N(PROC_ACK_N),
  .TOKEN_OUT(TOKEN_OUT), .MEM_DONE(MEM_DONE), .MEM_GRANT(MEM_GRANT),
  .TIMER_PRESET(TIMER_PRESET), .WATCHDOG_OUT(WATCHDOG_OUT),
  .TIMESTAMP(TIMESTAMP), .SYNC_TICK(SYNC_TICK),
  .SOFT_RESET_OUT(SOFT_RESET_OUT)
);

//--- tb.sv
`timescale 1ns/1ps
module tb;
  import ring_ctrl_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int          STEP = 4;
  localparam logic [15:0] ID   = 16'h5678;
  logic        clk_sys  = 1'b0;
  logic        reset_n  = 1'b0;
  logic        strobe_n = 1'b1;
  logic        rd       = 1'b0;
  logic [7:0]  addr     = 8'h00;
  logic [15:0] wdata    = 16'h0000;
  logic [15:0] preset   = 16'h0012;
  logic        mem_req  = 1'b0;
  logic        mem_done = 1'b0;
  logic        pass_en  = 1'b0;
  logic        inject   = 1'b0;
  logic        ack_d    = 1'b1;
  logic [15:0] rdata, tstamp, v;
  logic        rdata_oe, ack_n, tok_out, tok_in, grant, wd_out, tick, srst;
  logic [15:0] exp_q[$];
  int          bad_count = 0;
  int          n_tests   = 0;
  int          seed      = 94;
  int          tok_cnt   = 0;
  int          g_cnt     = 0;
  int          w_cnt     = 0;
  int          s_cnt     = 0;
  int          k, n, g, i;

  always #4 clk_sys = ~clk_sys;

  token_ring_global_control #(
    .STEP_CYCLES(STEP), .ID_VERSION(4'h8), .ID_REVISION(4'h7),
    .ID_FOUNDRY(4'h6), .ID_TYPE(4'h5)
  ) i_dut (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .PROC_STROBE_N(strobe_n),
    .PROC_READ(rd), .PROC_ADDR(addr), .PROC_WDATA(wdata),
    .PROC_RDATA(rdata), .PROC_RDATA_OE(rdata_oe), .PROC_ACK_N(ack_n),
    .TOKEN_IN(tok_in), .TOKEN_OUT(tok_out), .MEM_REQ(mem_req),
    .MEM_DONE(mem_done), .MEM_GRANT(grant), .TIMER_PRESET(preset),
    .WATCHDOG_OUT(wd_out), .TIMESTAMP(tstamp), .SYNC_TICK(tick),
    .SOFT_RESET_OUT(srst)
  );

  ring_neighbour i_nb (
    .clk(clk_sys), .rst_n(reset_n), .token_out(tok_out),
    .pass_en(pass_en), .inject(inject), .token_in(tok_in)
  );

  // ----------------------------------------
  // monitor and event counters
  // ----------------------------------------
  always @(negedge clk_sys)
  begin
    tok_cnt += int'(tok_out === 1'b1);
    g_cnt += int'(grant === 1'b1);
    w_cnt += int'(wd_out === 1'b1);
    s_cnt += int'(srst === 1'b1);
    if (ack_n === 1'b0 && ack_d === 1'b1 && rdata_oe === 1'b1)
    begin
      n_tests++;
      if (exp_q.size() == 0 || rdata !== exp_q[0])
      begin
        bad_count++;
        $display("CHECK FAILED at %0t: read data %h", $time, rdata);
      end
      if (exp_q.size() != 0)
        void'(exp_q.pop_front());
    end
    ack_d <= ack_n;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic print_verdict;
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic tmo(input logic hit);
    if (hit)
    begin
      chk(1'b0, "timeout");
      print_verdict();
    end
  endtask

  task automatic wt_ack(input logic lvl);
    k = 0;
    while (ack_n !== lvl && k < 20)
    begin
      @(negedge clk_sys);
      k++;
    end
    tmo(k >= 20);
  endtask

  // strobe held one cycle past the ack so the access is seen whole
  task automatic acc(input logic r, input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    {strobe_n, rd, addr, wdata} = {1'b0, r, a, d};
    wt_ack(1'b0);
    @(negedge clk_sys);
    strobe_n = 1'b1;
    wt_ack(1'b1);
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic rdx(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    acc(1'b1, a, 16'h0000);
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask

  task automatic wt_grant;
    k = 0;
    while (grant !== 1'b1 && k < 40)
    begin
      @(negedge clk_sys);
      k++;
    end
    tmo(k >= 40);
  endtask

  task automatic wt_change;
    k = 0;
    do
    begin
      @(negedge clk_sys);
      k++;
    end while (tstamp === v && k < 40);
    tmo(k >= 40);
  endtask

  task automatic tick_gap;
    g = 0;
    do
    begin
      @(negedge clk_sys);
      g++;
    end while (tick !== 1'b1 && g < 100);
    tmo(g >= 100);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(negedge clk_sys);
    reset_n = 1'b1;
    rdx(ID_CMD_OFFSET, ID);
    rdx(CONFIG_OFFSET, CONFIG_RESET);
    rdx(8'h04, 16'h0000);
    acc(1'b0, ID_CMD_OFFSET, 16'hfff8);
    rdx(ID_CMD_OFFSET, ID);
    for (i = 0; i < 3; i++)
    begin
      v = 16'($random(seed)) & 16'hffe0;
      acc(1'b0, CONFIG_OFFSET, v);
      rdx(CONFIG_OFFSET, v);
    end
    acc(1'b0, CONFIG_OFFSET, 16'h0000);
    n = tok_cnt;
    acc(1'b0, ID_CMD_OFFSET, 16'h0001);
    repeat (4) @(negedge clk_sys);
    chk(tok_cnt == n + 1, "launch");
    acc(1'b0, CONFIG_OFFSET, 16'h0004);
    n = tok_cnt;
    g = g_cnt;
    mem_req = 1'b1;
    acc(1'b0, ID_CMD_OFFSET, 16'h0001);
    pulse(inject);
    repeat (12) @(negedge clk_sys);
    chk(tok_cnt == n && g_cnt == g, "disabled ring");
    acc(1'b0, CONFIG_OFFSET, 16'h0000);
    mem_req = 1'b0;
    n = tok_cnt;
    g = g_cnt;
    pulse(inject);
    repeat (10) @(negedge clk_sys);
    chk(tok_cnt == n + 1 && g_cnt == g, "idle pass");
    mem_req = 1'b1;
    pulse(inject);
    wt_grant();
    n = tok_cnt;
    repeat (6) @(negedge clk_sys);
    chk(tok_cnt == n && grant === 1'b1, "grant held");
    pulse(mem_done);
    mem_req = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(tok_cnt == n + 1 && grant === 1'b0, "pass on");
    acc(1'b0, CONFIG_OFFSET, 16'h0002);
    mem_req = 1'b1;
    pass_en = 1'b1;
    acc(1'b0, ID_CMD_OFFSET, 16'h0001);
    wt_grant();
    pass_en = 1'b0;
    n = tok_cnt;
    pulse(mem_done);
    repeat (10) @(negedge clk_sys);
    chk(grant === 1'b1 && tok_cnt == n, "priority keep");
    mem_req = 1'b0;
    n = s_cnt;
    acc(1'b0, ID_CMD_OFFSET, 16'h0004);
    chk(s_cnt == n + 1 && grant === 1'b0, "soft reset");
    rdx(CONFIG_OFFSET, CONFIG_RESET);
    acc(1'b0, ID_CMD_OFFSET, 16'h0002);
    g = 0;
    n = 0;
    k = 0;
    while (wd_out !== 1'b1 && k < 100)
    begin
      @(negedge clk_sys);
      k++;
      g += int'(tstamp === 16'h000a);
      n += int'(tstamp === 16'h0010);
    end
    tmo(k >= 100);
    chk(k > 30 && k < 56, "wd interval");
    chk(g == 0 && n > 0, "decimal count");
    n = w_cnt;
    acc(1'b0, CONFIG_OFFSET, 16'h0001);
    repeat (80) @(negedge clk_sys);
    chk(wd_out === 1'b0 && w_cnt - n < 8, "wd masked");
    acc(1'b0, CONFIG_OFFSET, 16'h0008);
    v = tstamp;
    wt_change();
    v = tstamp;
    wt_change();
    chk(k == STEP && tstamp === v - 16'h0001 && v > 16'hfff0, "stamp");
    for (i = 0; i < 2; i++)
    begin
      acc(1'b0, CONFIG_OFFSET, i == 0 ? 16'h0010 : 16'h0000);
      tick_gap();
      tick_gap();
      chk(g == (i == 0 ? 32 : 30), "sync divide");
    end
    print_verdict();
  end
endmodule
